/* File: config_word_decoder.sv */
// configuration word storage, decode and reset time-out sequencing
`timescale 1ns/10ps
`default_nettype none
`include "config_word_decoder_defs.svh"

// Behaviour
// - programmed bit reads zero, erased bit reads one.
// - configuration word sits at address 2007h.
// - region 2000h-3FFFh answers only in programming mode.
// - 2K variant: 11 off, 10 0400h-, 01 0200h-, 00 whole 07FFh.
// - 1K variant: 11 and 10 off, 01 0200h-03FFh, 00 all.
// - bit 7 always reads one.
// - bit 6 one enables brown-out reset.
// - bit 3 zero enables power-up delay timer.
// - bit 2 one enables watchdog.
// - bits 1-0 pick RC, high-speed, standard or low-power crystal.
// - brown-out enable forces the power-up delay on.
// - watchdog only switched off by the word, nothing at runtime.
// - sleep ends on external reset, watchdog wake or interrupt.
// - power-up delay after power-up; start-up timer until osc stable.
// - crystal modes accept an external clock on the osc input.
// - start-up timer counts 1024 osc edges, crystal modes only.
// - after brown-out recovery the power-up delay runs 72 ms.
module config_word_decoder #(
    parameter int unsigned PROG_WORDS = `CFG_PROG_WORDS,
    parameter int unsigned POWERUP_DELAY_TIMER_CYCLES =
        `CFG_POWERUP_DELAY_TIMER_TIME_MS * `CFG_CLK_FREQ_KHZ,
    parameter int unsigned OST_CYCLES = `CFG_OST_OSC_CYCLES
) (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic PROG_MODE_I,
    input wire logic [`CFG_ADDR_W-1:0] PROG_ADDR_I,
    input wire logic PROG_WE_I,
    input wire logic PROG_RE_I,
    input wire logic PROG_ERASE_I,
    input wire logic [`CFG_WORD_W-1:0] PROG_WDATA_I,
    output logic [`CFG_WORD_W-1:0] PROG_RDATA_O,
    output logic PROG_RVALID_O,
    input wire logic OSCILLATOR_INPUT_PIN_I,
    input wire logic BROWNOUT_I,
    input wire logic MCLR_N_I,
    input wire logic SLEEP_REQ_I,
    input wire logic WDT_TIMEOUT_I,
    input wire logic INT_I,
    output logic DEVICE_RESET_N_O,
    output logic SLEEPING_O,
    output logic BROWNOUT_RESET_EN_O,
    output logic POWERUP_DELAY_EN_O,
    output logic WATCHDOG_EN_O,
    output logic [1:0] OSCILLATOR_SELECT_O,
    output logic PROTECT_EN_O,
    output logic [`CFG_PC_W-1:0] PROTECT_LO_O,
    output logic [`CFG_PC_W-1:0] PROTECT_HI_O
);
    localparam logic [`CFG_PC_W-1:0] PROT_TOP = `CFG_PC_W'(PROG_WORDS - 1);
    localparam int unsigned CP_LSB [`CFG_CP_COPIES] = '{`CFG_CP_LSB_0,
        `CFG_CP_LSB_1, `CFG_CP_LSB_2, `CFG_CP_LSB_3};

    config_word_decoder_pkg::reset_state_e state_r, state_nxt;
    logic [`CFG_WORD_W-1:0] cfg_r;
    logic [`CFG_WORD_W-1:0] cfg_view;
    logic prog_space, prog_hit;
    logic bor_en_r, powerup_delay_timer_en_r, wdt_en_r, prot_en_r;
    logic [1:0] osc_sel_r;
    logic [`CFG_PC_W-1:0] prot_lo_r;
    logic prot_en_nxt;
    logic [`CFG_PC_W-1:0] prot_lo_nxt;
    logic [1:0] code_protect_field;
    logic [`CFG_CP_COPIES-1:0] cp_match;
    logic brownout_reset_enable, powerup_delay_enable_n, watchdog_enable;
    logic [1:0] oscillator_select;
    logic powerup_delay_timer_on, crystal_live, crystal_held, brownout_hit, wake;
    logic osc_d_r, osc_tick;
    logic powerup_delay_timer_start, powerup_delay_timer_done, ost_start, ost_done, seq_abort;

    // stored word always shows the unimplemented bit as one
    assign cfg_view = cfg_r | (`CFG_WORD_W'(1) << `CFG_BIT_UNIMPL);
    assign prog_space = PROG_MODE_I && (PROG_ADDR_I >= `CFG_SPACE_LO) &&
        (PROG_ADDR_I <= `CFG_SPACE_HI);
    assign prog_hit = prog_space && (PROG_ADDR_I == `CFG_WORD_ADDR);

    // eprom cells: a write can only program ones to zeros; erase restores
    // ones. reset reloads the erased value since no real cell is modelled.
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            cfg_r <= `CFG_ERASED;
        end else if (prog_hit && PROG_ERASE_I) begin
            cfg_r <= `CFG_ERASED;
        end else if (prog_hit && PROG_WE_I) begin
            cfg_r <= cfg_r & PROG_WDATA_I;
        end
    end

    // unused test space reads erased; outside programming reads zero
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            PROG_RDATA_O <= '0;
            PROG_RVALID_O <= 1'b0;
        end else begin
            PROG_RVALID_O <= PROG_RE_I && prog_space;
            if (PROG_RE_I && prog_hit) begin
                PROG_RDATA_O <= cfg_view;
            end else if (PROG_RE_I && prog_space) begin
                PROG_RDATA_O <= `CFG_ERASED;
            end else begin
                PROG_RDATA_O <= '0;
            end
        end
    end

    // every protect copy must agree, else the scheme is not applied
    generate
        for (genvar g = 0; g < `CFG_CP_COPIES; g++) begin : g_cp
            assign cp_match[g] = cfg_r[CP_LSB[g] +: 2] == code_protect_field;
        end
    endgenerate

    assign code_protect_field = cfg_r[`CFG_CP_LSB_0 +: 2];
    assign brownout_reset_enable = cfg_r[`CFG_BIT_BOR_EN];
    assign powerup_delay_enable_n = cfg_r[`CFG_BIT_POWERUP_DELAY_TIMER_EN_N];
    assign watchdog_enable = cfg_r[`CFG_BIT_WDT_EN];
    assign oscillator_select = cfg_r[`CFG_OSC_LSB +: 2];
    assign powerup_delay_timer_on = brownout_reset_enable || !powerup_delay_enable_n;

    always_comb begin
        prot_en_nxt = 1'b0;
        prot_lo_nxt = `CFG_PROT_LO_00;
        if (&cp_match) begin
            case (code_protect_field)
                2'h2: begin
                    prot_en_nxt = (PROG_WORDS > 1024);
                    prot_lo_nxt = `CFG_PROT_LO_10;
                end
                2'h1: begin
                    prot_en_nxt = 1'b1;
                    prot_lo_nxt = `CFG_PROT_LO_01;
                end
                2'h0: begin
                    prot_en_nxt = 1'b1;
                    prot_lo_nxt = `CFG_PROT_LO_00;
                end
                default: begin
                    prot_en_nxt = 1'b0;
                    prot_lo_nxt = `CFG_PROT_LO_00;
                end
            endcase
        end
    end

    // settings follow the word only while the core is held in reset
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            bor_en_r <= 1'b1;
            powerup_delay_timer_en_r <= 1'b1;
            wdt_en_r <= 1'b1;
            osc_sel_r <= 2'h3;
            prot_en_r <= 1'b0;
            prot_lo_r <= '0;
        end else if (!DEVICE_RESET_N_O) begin
            bor_en_r <= brownout_reset_enable;
            powerup_delay_timer_en_r <= powerup_delay_timer_on;
            wdt_en_r <= watchdog_enable;
            osc_sel_r <= oscillator_select;
            prot_en_r <= prot_en_nxt;
            prot_lo_r <= prot_lo_nxt;
        end
    end

    // osc input is synchronous here; a driven clock or crystal both tick
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            osc_d_r <= 1'b0;
        end else begin
            osc_d_r <= OSCILLATOR_INPUT_PIN_I;
        end
    end
    assign osc_tick = OSCILLATOR_INPUT_PIN_I && !osc_d_r;

    assign crystal_live =
        oscillator_select != config_word_decoder_pkg::RESISTOR_CAPACITOR_MODE;
    assign crystal_held =
        osc_sel_r != config_word_decoder_pkg::RESISTOR_CAPACITOR_MODE;
    assign brownout_hit = BROWNOUT_I && ((state_r ==
        config_word_decoder_pkg::ST_POR) ? brownout_reset_enable : bor_en_r);
    // a watchdog wake needs the watchdog on; there is no runtime stop
    assign wake = !MCLR_N_I || INT_I || (WDT_TIMEOUT_I && wdt_en_r);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            config_word_decoder_pkg::ST_POR: begin
                if (brownout_hit) begin
                    state_nxt = config_word_decoder_pkg::ST_POR;
                end else if (powerup_delay_timer_on) begin
                    state_nxt = config_word_decoder_pkg::ST_POWERUP_DELAY_TIMER;
                end else if (crystal_live) begin
                    state_nxt = config_word_decoder_pkg::ST_OST;
                end else begin
                    state_nxt = config_word_decoder_pkg::ST_RUN;
                end
            end
            config_word_decoder_pkg::ST_POWERUP_DELAY_TIMER: begin
                if (brownout_hit) begin
                    state_nxt = config_word_decoder_pkg::ST_POR;
                end else if (powerup_delay_timer_done) begin
                    state_nxt = crystal_held ?
                        config_word_decoder_pkg::ST_OST :
                        config_word_decoder_pkg::ST_RUN;
                end
            end
            config_word_decoder_pkg::ST_OST: begin
                if (brownout_hit) begin
                    state_nxt = config_word_decoder_pkg::ST_POR;
                end else if (ost_done) begin
                    state_nxt = config_word_decoder_pkg::ST_RUN;
                end
            end
            config_word_decoder_pkg::ST_RUN: begin
                if (brownout_hit) begin
                    state_nxt = config_word_decoder_pkg::ST_POR;
                end else if (SLEEP_REQ_I && MCLR_N_I) begin
                    state_nxt = config_word_decoder_pkg::ST_SLEEP;
                end
            end
            config_word_decoder_pkg::ST_SLEEP: begin
                if (brownout_hit) begin
                    state_nxt = config_word_decoder_pkg::ST_POR;
                end else if (wake) begin
                    state_nxt = (crystal_held && MCLR_N_I) ?
                        config_word_decoder_pkg::ST_OST :
                        config_word_decoder_pkg::ST_RUN;
                end
            end
            default: begin
                state_nxt = config_word_decoder_pkg::ST_POR;
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            state_r <= config_word_decoder_pkg::ST_POR;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign powerup_delay_timer_start = (state_r == config_word_decoder_pkg::ST_POR) &&
        (state_nxt == config_word_decoder_pkg::ST_POWERUP_DELAY_TIMER);
    assign ost_start = (state_r != config_word_decoder_pkg::ST_OST) &&
        (state_nxt == config_word_decoder_pkg::ST_OST);
    assign seq_abort = (state_nxt == config_word_decoder_pkg::ST_POR);

    delay_counter #(
        .W(32),
        .COUNT(32'(POWERUP_DELAY_TIMER_CYCLES))
    ) u_powerup_delay_timer (
        .clk_i(CLK_I),
        .rstn_i(RESETN_I),
        .start_i(powerup_delay_timer_start),
        .abort_i(seq_abort),
        .tick_i(1'b1),
        .done_o(powerup_delay_timer_done)
    );

    delay_counter #(
        .W(32),
        .COUNT(32'(OST_CYCLES))
    ) u_oscillator_startup_timer (
        .clk_i(CLK_I),
        .rstn_i(RESETN_I),
        .start_i(ost_start),
        .abort_i(seq_abort),
        .tick_i(osc_tick),
        .done_o(ost_done)
    );

    assign DEVICE_RESET_N_O = MCLR_N_I &&
        ((state_r == config_word_decoder_pkg::ST_RUN) ||
        (state_r == config_word_decoder_pkg::ST_SLEEP));
    assign SLEEPING_O = state_r == config_word_decoder_pkg::ST_SLEEP;
    assign BROWNOUT_RESET_EN_O = bor_en_r;
    assign POWERUP_DELAY_EN_O = powerup_delay_timer_en_r;
    assign WATCHDOG_EN_O = wdt_en_r;
    assign OSCILLATOR_SELECT_O = osc_sel_r;
    assign PROTECT_EN_O = prot_en_r;
    assign PROTECT_LO_O = prot_lo_r;
    assign PROTECT_HI_O = PROT_TOP;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    property p_unimpl_one;
        PROG_RE_I && prog_hit |=> PROG_RDATA_O[`CFG_BIT_UNIMPL];
    endproperty
    a_unimpl_one: assert property (p_unimpl_one)
        else $error("unimplemented bit read as zero");

    property p_no_access_outside;
        PROG_RE_I && !PROG_MODE_I |=> !PROG_RVALID_O && PROG_RDATA_O == '0;
    endproperty
    a_no_access_outside: assert property (p_no_access_outside)
        else $error("config space answered outside programming mode");

    property p_readback;
        PROG_RE_I && prog_hit && !PROG_WE_I && !PROG_ERASE_I
            |=> PROG_RDATA_O == cfg_view;
    endproperty
    a_readback: assert property (p_readback)
        else $error("config word readback mismatch");

    property p_program_clears_only;
        PROG_WE_I && prog_hit && !PROG_ERASE_I
            |=> (cfg_r & ~$past(cfg_r)) == '0;
    endproperty
    a_program_clears_only: assert property (p_program_clears_only)
        else $error("programming set a bit to one");

    property p_powerup_delay_timer_forced;
        bor_en_r |-> powerup_delay_timer_en_r;
    endproperty
    a_powerup_delay_timer_forced: assert property (p_powerup_delay_timer_forced)
        else $error("brown-out enabled without power-up delay");

    property p_frozen;
        $past(RESETN_I) && $past(DEVICE_RESET_N_O)
            |-> $stable(wdt_en_r) && $stable(prot_lo_r) && $stable(osc_sel_r);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("settings changed during operation");

    property p_ost_crystal_only;
        state_r == config_word_decoder_pkg::ST_OST |-> crystal_held;
    endproperty
    a_ost_crystal_only: assert property (p_ost_crystal_only)
        else $error("start-up timer ran in RC mode");

    property p_held_in_reset;
        state_r inside {config_word_decoder_pkg::ST_POR,
            config_word_decoder_pkg::ST_POWERUP_DELAY_TIMER,
            config_word_decoder_pkg::ST_OST} |-> !DEVICE_RESET_N_O;
    endproperty
    a_held_in_reset: assert property (p_held_in_reset)
        else $error("reset released during time-out");

    property p_sleep_wake;
        SLEEPING_O && (INT_I || !MCLR_N_I) |=> !SLEEPING_O;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("sleep not left on wake event");

    property p_brownout;
        DEVICE_RESET_N_O && bor_en_r && BROWNOUT_I
            |=> state_r == config_word_decoder_pkg::ST_POR;
    endproperty
    a_brownout: assert property (p_brownout)
        else $error("brown-out did not reset the sequence");

    property p_protect_full;
        (&cp_match) && code_protect_field == 2'h0
            |-> prot_en_nxt && prot_lo_nxt == `CFG_PROT_LO_00;
    endproperty
    a_protect_full: assert property (p_protect_full)
        else $error("full protection not decoded");

    c_reach_run: cover property (
        state_r == config_word_decoder_pkg::ST_OST ##1
        state_r == config_word_decoder_pkg::ST_RUN);
    c_sleep_wake: cover property (SLEEPING_O ##1 !SLEEPING_O);
    c_brownout: cover property (
        state_r == config_word_decoder_pkg::ST_POWERUP_DELAY_TIMER && brownout_hit);
endmodule // config_word_decoder
`default_nettype wire

/* File: config_word_decoder_defs.svh */
// constants for the configuration word decoder
`ifndef CONFIG_WORD_DECODER_DEFS_SVH
`define CONFIG_WORD_DECODER_DEFS_SVH

`define CFG_WORD_W 14
`define CFG_ADDR_W 14
`define CFG_PC_W 11
`define CFG_WORD_ADDR 14'h2007
`define CFG_SPACE_LO 14'h2000
`define CFG_SPACE_HI 14'h3FFF
`define CFG_ERASED 14'h3FFF
`define CFG_BIT_UNIMPL 7
`define CFG_BIT_BOR_EN 6
`define CFG_BIT_POWERUP_DELAY_TIMER_EN_N 3
`define CFG_BIT_WDT_EN 2
`define CFG_OSC_LSB 0
`define CFG_CP_LSB_0 4
`define CFG_CP_LSB_1 8
`define CFG_CP_LSB_2 10
`define CFG_CP_LSB_3 12
`define CFG_CP_COPIES 4
`define CFG_PROG_WORDS 2048
`define CFG_PROT_LO_10 11'h400
`define CFG_PROT_LO_01 11'h200
`define CFG_PROT_LO_00 11'h000
`define CFG_CLK_FREQ_KHZ 40000
`define CFG_POWERUP_DELAY_TIMER_TIME_MS 72
`define CFG_OST_OSC_CYCLES 1024

`endif

/* File: config_word_decoder_pkg.sv */
// types shared by the configuration word decoder
package config_word_decoder_pkg;
    typedef enum logic [2:0] {
        ST_POR = 3'h0,
        ST_POWERUP_DELAY_TIMER = 3'h1,
        ST_OST = 3'h3,
        ST_RUN = 3'h2,
        ST_SLEEP = 3'h6
    } reset_state_e;

    typedef enum logic [1:0] {
        LOW_POWER_CRYSTAL_MODE = 2'h0,
        STANDARD_CRYSTAL_MODE = 2'h1,
        HIGH_SPEED_CRYSTAL_MODE = 2'h2,
        RESISTOR_CAPACITOR_MODE = 2'h3
    } oscillator_select_e;
endpackage

/* File: delay_counter.sv */
// event counter that reports when a loaded count has elapsed
`timescale 1ns/10ps
`default_nettype none
module delay_counter #(
    parameter int unsigned W = 22,
    parameter logic [W-1:0] COUNT = W'(1)
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic tick_i,
    output logic done_o
);
    logic busy_r;
    logic [W-1:0] cnt_r;

    always_ff @(posedge clk_i) begin
        if (!rstn_i || abort_i) begin
            busy_r <= 1'b0;
            cnt_r <= '0;
        end else if (start_i) begin
            busy_r <= 1'b1;
            cnt_r <= COUNT;
        end else if (busy_r && tick_i) begin
            cnt_r <= cnt_r - W'(1);
            if (cnt_r == W'(1)) begin
                busy_r <= 1'b0;
            end
        end
    end

    assign done_o = busy_r && tick_i && (cnt_r == W'(1));
endmodule // delay_counter
`default_nettype wire

/* File: cfg_programmer.sv */
// model of the external programmer driving the programming port
`timescale 1ns/10ps
`default_nettype none
`include "config_word_decoder_defs.svh"
module cfg_programmer (
    input wire logic clk_i,
    output logic mode_o,
    output logic [`CFG_ADDR_W-1:0] addr_o,
    output logic we_o,
    output logic re_o,
    output logic erase_o,
    output logic [`CFG_WORD_W-1:0] wdata_o
);
    initial begin
        mode_o = 1'b0;
        addr_o = 14'h0000;
        {we_o, re_o, erase_o} = 3'h0;
        wdata_o = 14'h0000;
    end

    function automatic logic [13:0] make_word(input logic [1:0] cp,
        input logic bor, pdn, wdt, input logic [1:0] osc, input logic keep);
        logic pd;
        // keep off only when a scenario wants the forced-on path
        pd = pdn & ~(keep & bor);
        return {cp, cp, cp, 1'b1, bor, cp, pd, wdt, osc};
    endfunction

    task automatic set_mode(input logic m);
        @(negedge clk_i);
        mode_o = m;
    endtask

    // released address and data go inverted, never stale
    task automatic pulse(input logic [13:0] a, input logic w, r, e,
        input logic [13:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        {we_o, re_o, erase_o} = {w, r, e};
        @(negedge clk_i);
        {we_o, re_o, erase_o} = 3'h0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask

    // writes only clear bits, so erase first
    task automatic program_word(input logic [13:0] w);
        pulse(14'h2007, 1'b0, 1'b0, 1'b1, 14'h0000);
        pulse(14'h2007, 1'b1, 1'b0, 1'b0, w);
    endtask
endmodule // cfg_programmer
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the configuration word decoder
`timescale 1ns/10ps
`default_nettype none
`include "config_word_decoder_defs.svh"
module tb_top;
    localparam int unsigned POWERUP_DELAY_TIMER = 20;
    localparam int unsigned OSCILLATOR_STARTUP_TIMER = 4;
    logic clk = 1'b0, resetn = 1'b0, osc = 1'b0, osc_run = 1'b0;
    logic brown = 1'b0, mclr_n = 1'b1, slp = 1'b0, wdt_to = 1'b0;
    logic irq = 1'b0;
    logic mode, we, re, erase, rv2k, rst2k, sl2k, bor, pde, wde;
    logic en2k, en1k, rv1k, rst1k, sl1k;
    logic [13:0] addr, wdata, rd2k, rd1k;
    logic [1:0] oscsel;
    logic [10:0] lo2k, lo1k, hi2k, hi1k;
    int num_errors = 0;
    int compares = 0;

    always #12.5 clk = ~clk;
    // stands still while stopped so the start-up count stalls
    always #50 if (osc_run) osc = ~osc;

    cfg_programmer u_prog (.clk_i(clk), .mode_o(mode), .addr_o(addr),
        .we_o(we), .re_o(re), .erase_o(erase), .wdata_o(wdata));
    config_word_decoder #(.PROG_WORDS(2048), .POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER),
        .OST_CYCLES(OSCILLATOR_STARTUP_TIMER)) u_dut (.CLK_I(clk), .RESETN_I(resetn),
        .PROG_MODE_I(mode), .PROG_ADDR_I(addr), .PROG_WE_I(we),
        .PROG_RE_I(re), .PROG_ERASE_I(erase), .PROG_WDATA_I(wdata),
        .PROG_RDATA_O(rd2k), .PROG_RVALID_O(rv2k),
        .OSCILLATOR_INPUT_PIN_I(osc), .BROWNOUT_I(brown),
        .MCLR_N_I(mclr_n), .SLEEP_REQ_I(slp), .WDT_TIMEOUT_I(wdt_to),
        .INT_I(irq), .DEVICE_RESET_N_O(rst2k), .SLEEPING_O(sl2k),
        .BROWNOUT_RESET_EN_O(bor), .POWERUP_DELAY_EN_O(pde),
        .WATCHDOG_EN_O(wde), .OSCILLATOR_SELECT_O(oscsel),
        .PROTECT_EN_O(en2k), .PROTECT_LO_O(lo2k), .PROTECT_HI_O(hi2k));
    config_word_decoder #(.PROG_WORDS(1024), .POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER),
        .OST_CYCLES(OSCILLATOR_STARTUP_TIMER)) u_dut1k (.CLK_I(clk), .RESETN_I(resetn),
        .PROG_MODE_I(mode), .PROG_ADDR_I(addr), .PROG_WE_I(we),
        .PROG_RE_I(re), .PROG_ERASE_I(erase), .PROG_WDATA_I(wdata),
        .PROG_RDATA_O(rd1k), .PROG_RVALID_O(rv1k),
        .OSCILLATOR_INPUT_PIN_I(osc), .BROWNOUT_I(brown),
        .MCLR_N_I(mclr_n), .SLEEP_REQ_I(slp), .WDT_TIMEOUT_I(wdt_to),
        .INT_I(irq), .DEVICE_RESET_N_O(rst1k), .SLEEPING_O(sl1k),
        .BROWNOUT_RESET_EN_O(), .POWERUP_DELAY_EN_O(),
        .WATCHDOG_EN_O(), .OSCILLATOR_SELECT_O(),
        .PROTECT_EN_O(en1k), .PROTECT_LO_O(lo1k), .PROTECT_HI_O(hi1k));

    task automatic chk(input logic [15:0] got, exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wait_rst(input int n, input logic v);
        for (int i = 0; i < n && rst2k !== v; i++)
            @(negedge clk);
        chk(16'(rst2k), 16'(v));
        chk(16'(rst1k), 16'(v));
    endtask

    // settings are only captured while the core is held in reset
    task automatic relatch;
        @(negedge clk) mclr_n = 1'b0;
        repeat (3) @(negedge clk);
        chk(16'(rst2k), 16'h0000);
        mclr_n = 1'b1;
        wait_rst(4, 1'b1);
    endtask

    task automatic rd(input logic [13:0] a, input logic [15:0] exp);
        u_prog.pulse(a, 1'b0, 1'b1, 1'b0, 14'h0000);
        chk(16'({rv2k, rd2k}), exp);
        chk(16'({rv1k, rd1k}), exp);
    endtask

    task automatic chk_cfg(input logic [13:0] w);
        logic [1:0] cp;
        logic same, e2, e1;
        logic [10:0] lo;
        cp = w[5:4];
        same = w[13:12] == cp && w[11:10] == cp && w[9:8] == cp;
        e2 = same && cp != 2'h3;
        e1 = same && !cp[1];
        lo = cp[1] ? 11'h400 : (cp[0] ? 11'h200 : 11'h000);
        chk(16'({bor, pde, wde, oscsel}),
            16'({w[6], w[6] | ~w[3], w[2], w[1:0]}));
        chk(16'({en2k, en2k ? lo2k : 11'h000}),
            16'({e2, e2 ? lo : 11'h000}));
        chk(16'({en1k, en1k ? lo1k : 11'h000}),
            16'({e1, e1 ? lo : 11'h000}));
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        complete_run();
    end

    initial begin
        logic [13:0] w;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        repeat (POWERUP_DELAY_TIMER - 4) @(negedge clk);
        chk(16'(rst2k), 16'h0000);
        wait_rst(10, 1'b1);
        chk_cfg(14'h3FFF);
        chk(16'(hi2k), 16'h07FF);
        chk(16'(hi1k), 16'h03FF);
        u_prog.set_mode(1'b1);
        rd(14'h2007, 16'h7FFF);
        rd(14'h3FFF, 16'h7FFF);
        rd(14'h1FFF, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            @(negedge clk) slp = 1'b1;
            @(negedge clk) slp = 1'b0;
            chk(16'(sl2k), 16'h0001);
            chk(16'(sl1k), 16'h0001);
            // one wake source per pass: interrupt, watchdog, external reset
            {irq, wdt_to, mclr_n} = {k == 0, k == 1, k != 2};
            @(negedge clk) {irq, wdt_to, mclr_n} = 3'h1;
            wait_rst(4, 1'b1);
            chk(16'(sl2k), 16'h0000);
        end
        w = u_prog.make_word(2'h2, 1'b0, 1'b0, 1'b0, 2'h1, 1'b1);
        u_prog.program_word(w);
        rd(14'h2007, 16'({1'b1, w | 14'h0080}));
        u_prog.set_mode(1'b0);
        u_prog.program_word(14'h0000);
        rd(14'h2007, 16'h0000);
        u_prog.set_mode(1'b1);
        rd(14'h2007, 16'({1'b1, w | 14'h0080}));
        for (int i = 0; i < 8; i++) begin
            w = u_prog.make_word(i[1:0], i[0], i[1], i[2], i[2:1], 1'b0);
            u_prog.program_word(w);
            relatch();
            chk_cfg(w);
        end
        u_prog.program_word(14'h0000);
        chk_cfg(w);
        u_prog.program_word(14'h3FCF);
        relatch();
        chk_cfg(14'h3FCF);
        w = u_prog.make_word(2'h3, 1'b0, 1'b0, 1'b0, 2'h3, 1'b1);
        u_prog.program_word(w);
        relatch();
        @(negedge clk) slp = 1'b1;
        @(negedge clk) {slp, wdt_to} = 2'h1;
        @(negedge clk) {wdt_to, irq} = 2'h1;
        chk(16'(sl2k), 16'h0001);
        @(negedge clk) irq = 1'b0;
        wait_rst(4, 1'b1);
        chk(16'(sl2k), 16'h0000);
        w = u_prog.make_word(2'h3, 1'b0, 1'b0, 1'b1, 2'h1, 1'b1);
        u_prog.program_word(w);
        relatch();
        @(negedge clk) brown = 1'b1;
        repeat (2) @(negedge clk);
        chk(16'(rst2k), 16'h0001);
        brown = 1'b0;
        w = u_prog.make_word(2'h3, 1'b1, 1'b0, 1'b1, 2'h1, 1'b1);
        u_prog.program_word(w);
        relatch();
        @(negedge clk) brown = 1'b1;
        repeat (2) @(negedge clk);
        chk(16'(rst2k), 16'h0000);
        brown = 1'b0;
        // a second dip inside the power-up delay restarts it
        repeat (POWERUP_DELAY_TIMER / 2) @(negedge clk);
        brown = 1'b1;
        @(negedge clk) brown = 1'b0;
        repeat (POWERUP_DELAY_TIMER + 8 * OSCILLATOR_STARTUP_TIMER) @(negedge clk);
        chk(16'(rst2k), 16'h0000);
        osc_run = 1'b1;
        wait_rst(12 * OSCILLATOR_STARTUP_TIMER, 1'b1);
        @(negedge clk) {slp, osc_run} = 2'h2;
        @(negedge clk) {slp, irq} = 2'h1;
        @(negedge clk) irq = 1'b0;
        repeat (8 * OSCILLATOR_STARTUP_TIMER) @(negedge clk);
        chk(16'(rst2k), 16'h0000);
        osc_run = 1'b1;
        wait_rst(12 * OSCILLATOR_STARTUP_TIMER, 1'b1);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
